// ==== common/ubt_pkg.sv ====
`default_nettype none
package ubt_pkg;
  localparam int UBT_ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] UBT_OFS_TMR_CTRL = 8'h00;
  localparam logic [7:0] UBT_OFS_TMR_COUNT = 8'h04;
  localparam logic [7:0] UBT_OFS_CMP_VALUE = 8'h08;
  localparam logic [7:0] UBT_OFS_ASYNC_MODE = 8'h0C;
  localparam logic [7:0] UBT_OFS_TX_SHIFT = 8'h10;
  localparam logic [7:0] UBT_OFS_TX_STATUS = 8'h14;

  // baud_timer_control fields
  localparam int UBT_TCTL_RUN_BIT = 0;
  localparam int UBT_TCTL_PRE_LSB = 1;
  localparam logic [7:0] UBT_TCTL_RESET = 8'h00;

  // async_mode_register fields
  localparam int UBT_AM_SCK_BIT = 0;
  localparam int UBT_AM_SL_BIT = 2;
  localparam int UBT_AM_CL_BIT = 3;
  localparam int UBT_AM_PS0_BIT = 4;
  localparam int UBT_AM_PS1_BIT = 5;
  localparam int UBT_AM_RXE_BIT = 6;
  localparam logic [7:0] UBT_AM_RESET = 8'h80;
  localparam logic [7:0] UBT_AM_WMASK = 8'h7D;

  localparam logic [9:0] UBT_CMP_RESET = 10'h000;
  localparam int UBT_PRESC_W = 5;

  // Serial clocks per bit and data bits per character, expressed as last index
  localparam logic [3:0] UBT_SMP_LAST = 4'hF;
  localparam logic [2:0] UBT_LAST_BIT_7 = 3'h6;
  localparam logic [2:0] UBT_LAST_BIT_8 = 3'h7;

  localparam logic [1:0] UBT_PAR_NONE = 2'h0;
  localparam logic [1:0] UBT_PAR_ZERO = 2'h1;
  localparam logic [1:0] UBT_PAR_ODD = 2'h2;
  localparam logic [1:0] UBT_PAR_EVEN = 2'h3;

  typedef enum logic [2:0] {
    UBT_TX_IDLE,
    UBT_TX_START,
    UBT_TX_DATA,
    UBT_TX_PARITY,
    UBT_TX_STOP
  } ubt_tx_state_t;
endpackage
`default_nettype wire

// ==== rtl/ubt_baud_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module ubt_baud_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [1:0] presc_sel,
  input wire logic [9:0] cmp_value,
  output logic [9:0] count,
  output logic ser_tick,
  output logic bclk
);
  import ubt_pkg::*;

  typedef struct packed {
    logic [UBT_PRESC_W-1:0] presc;
    logic [9:0] timer;
    logic tog;
    logic tick;
  } ubt_bg_state_t;

  ubt_bg_state_t st_ff;
  ubt_bg_state_t nxt_st;

  // Count-clock divide 2^n, n in {0,2,4,5}
  function automatic logic [UBT_PRESC_W-1:0] presc_mask(
    input logic [1:0] sel
  );
    case (sel)
      2'h0: presc_mask = 5'h00;
      2'h1: presc_mask = 5'h03;
      2'h2: presc_mask = 5'h0F;
      default: presc_mask = 5'h1F;
    endcase
  endfunction

  logic cnt_clk;
  logic match;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    nxt_st.presc = st_ff.presc + 5'h01;
    cnt_clk = (st_ff.presc & presc_mask(presc_sel)) ==
              presc_mask(presc_sel);
    match = st_ff.timer == cmp_value;
    if (!run) begin
      // Stopped: timer parked so a restart begins from a known phase
      nxt_st.timer = 10'h000;
      nxt_st.tog = 1'b0;
    end else if (cnt_clk) begin
      if (match) begin
        nxt_st.timer = 10'h000;
        nxt_st.tog = ~st_ff.tog;
        nxt_st.tick = ~st_ff.tog;
      end else begin
        nxt_st.timer = st_ff.timer + 10'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign count = st_ff.timer;
  assign ser_tick = st_ff.tick;
  assign bclk = st_ff.tog;
endmodule
`default_nettype wire

// ==== rtl/ubt_uart_tx.sv ====
// Contract
// - Baud timer: 10-bit up-counter, cleared on the count clock after match.
// - Compare value m, 0..1023, matched continuously against the timer.
// - Generator output toggles per match: half the match frequency.
// - Timer counts only while the control register's run bit is set.
// - Timer count is read only; writes to it have no effect.
// - Compare register read/write; value after reset not guaranteed.
// - Baud = clock / 2^n / (m+1) / 2 / 16, n in 0,2,4,5.
// - One bit period spans sixteen serial clock periods.
// - Writing a byte while idle starts a frame immediately, no enable.
// - Start, parity and stop bits are added automatically.
// - Completion interrupt raised when the shift register has emptied.
// - After a frame the line idles high until the next write.
// - Reset emptying the shift register raises no completion interrupt.
// - Writes during a frame are ignored; the frame continues.
// - Frame: start, 7 or 8 data, optional parity, 1 or 2 stop bits.
// - Parity select: 00 none, 01 zero, 10 odd, 11 even.
// - 7-bit characters send bits 0..6 only.
`timescale 1ns/1ps
`default_nettype none
module ubt_uart_tx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ubt_pkg::UBT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic txd,
  output logic transmit_complete_irq
);
  import ubt_pkg::*;

  typedef struct packed {
    logic [7:0] tctl;
    logic [9:0] cmp;
    logic [7:0] amode;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    ubt_tx_state_t transmit_shift_register;
    logic [3:0] smp;
    logic [2:0] bitn;
    logic stop_n;
    logic [7:0] shreg;
    logic par;
    logic line;
    logic irq;
  } ubt_top_state_t;

  ubt_top_state_t st_ff;
  ubt_top_state_t nxt_st;

  logic [9:0] bg_count;
  logic bg_tick;
  logic ser_tick;
  logic setup;
  logic access;
  logic [1:0] psel_mode;
  logic [2:0] last_bit;
  logic bit_end;

  function automatic logic addr_known(input logic [UBT_ADDR_W-1:0] a);
    case (a)
      UBT_OFS_TMR_CTRL, UBT_OFS_TMR_COUNT, UBT_OFS_CMP_VALUE,
      UBT_OFS_ASYNC_MODE, UBT_OFS_TX_SHIFT, UBT_OFS_TX_STATUS:
        addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  // Parity bit for the character as it will be sent
  function automatic logic parity_bit(
    input logic [7:0] d,
    input logic eight,
    input logic [1:0] mode
  );
    logic ones;
    ones = eight ? ^d : ^d[6:0];
    case (mode)
      UBT_PAR_ODD: parity_bit = ~ones;
      UBT_PAR_EVEN: parity_bit = ones;
      default: parity_bit = 1'b0;
    endcase
  endfunction

  ubt_baud_gen u_baud_gen (
    .pclk(pclk),
    .presetn(presetn),
    .run(st_ff.tctl[UBT_TCTL_RUN_BIT]),
    .presc_sel(st_ff.tctl[UBT_TCTL_PRE_LSB +: 2]),
    .cmp_value(st_ff.cmp),
    .count(bg_count),
    .ser_tick(ser_tick),
    .bclk()
  );

  always_comb begin
    nxt_st = st_ff;
    setup = psel && !penable;
    access = psel && penable && st_ff.rdy;
    psel_mode = {st_ff.amode[UBT_AM_PS1_BIT], st_ff.amode[UBT_AM_PS0_BIT]};
    last_bit = st_ff.amode[UBT_AM_CL_BIT] ? UBT_LAST_BIT_8 :
               UBT_LAST_BIT_7;
    bg_tick = st_ff.amode[UBT_AM_SCK_BIT] ? 1'b1 : ser_tick;
    bit_end = bg_tick && (st_ff.smp == UBT_SMP_LAST);
    nxt_st.irq = 1'b0;

    // Answer in the access cycle: data prepared during setup
    if (setup) begin
      nxt_st.rdy = 1'b1;
      nxt_st.err = !addr_known(paddr);
      nxt_st.rdata = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          UBT_OFS_TMR_CTRL: nxt_st.rdata = {24'h000000, st_ff.tctl};
          UBT_OFS_TMR_COUNT: nxt_st.rdata = {22'h000000, bg_count};
          UBT_OFS_CMP_VALUE: nxt_st.rdata = {22'h000000, st_ff.cmp};
          UBT_OFS_ASYNC_MODE: nxt_st.rdata = {24'h000000, st_ff.amode};
          UBT_OFS_TX_STATUS:
            nxt_st.rdata = {31'h00000000, st_ff.transmit_shift_register != UBT_TX_IDLE};
          default: nxt_st.rdata = 32'h0000_0000;
        endcase
      end
    end else if (access) begin
      nxt_st.rdy = 1'b0;
      nxt_st.err = 1'b0;
    end

    // Frame sequencer, one step per sixteen serial clocks
    if (st_ff.transmit_shift_register != UBT_TX_IDLE && bg_tick) begin
      nxt_st.smp = st_ff.smp + 4'h1;
    end
    case (st_ff.transmit_shift_register)
      UBT_TX_IDLE: begin
        nxt_st.line = 1'b1;
      end
      UBT_TX_START: begin
        if (bit_end) begin
          nxt_st.transmit_shift_register = UBT_TX_DATA;
          nxt_st.bitn = 3'h0;
          nxt_st.line = st_ff.shreg[0];
        end
      end
      UBT_TX_DATA: begin
        if (bit_end) begin
          if (st_ff.bitn == last_bit) begin
            if (psel_mode == UBT_PAR_NONE) begin
              nxt_st.transmit_shift_register = UBT_TX_STOP;
              nxt_st.stop_n = 1'b0;
              nxt_st.line = 1'b1;
            end else begin
              nxt_st.transmit_shift_register = UBT_TX_PARITY;
              nxt_st.line = st_ff.par;
            end
          end else begin
            nxt_st.bitn = st_ff.bitn + 3'h1;
            nxt_st.line = st_ff.shreg[st_ff.bitn + 3'h1];
          end
        end
      end
      UBT_TX_PARITY: begin
        if (bit_end) begin
          nxt_st.transmit_shift_register = UBT_TX_STOP;
          nxt_st.stop_n = 1'b0;
          nxt_st.line = 1'b1;
        end
      end
      UBT_TX_STOP: begin
        if (bit_end) begin
          if (st_ff.amode[UBT_AM_SL_BIT] && !st_ff.stop_n) begin
            nxt_st.stop_n = 1'b1;
          end else begin
            nxt_st.transmit_shift_register = UBT_TX_IDLE;
            nxt_st.irq = 1'b1;
          end
        end
      end
      default: begin
        nxt_st.transmit_shift_register = UBT_TX_IDLE;
        nxt_st.line = 1'b1;
      end
    endcase

    // Register writes take effect on the completing access edge
    if (access && pwrite) begin
      case (paddr)
        UBT_OFS_TMR_CTRL: nxt_st.tctl = pwdata[7:0];
        UBT_OFS_CMP_VALUE: nxt_st.cmp = pwdata[9:0];
        UBT_OFS_ASYNC_MODE:
          nxt_st.amode = (pwdata[7:0] & UBT_AM_WMASK) | UBT_AM_RESET;
        UBT_OFS_TX_SHIFT: begin
          // Busy writes dropped: frame in flight is left untouched
          if (st_ff.transmit_shift_register == UBT_TX_IDLE) begin
            nxt_st.transmit_shift_register = UBT_TX_START;
            nxt_st.smp = 4'h0;
            nxt_st.shreg = pwdata[7:0];
            nxt_st.par = parity_bit(pwdata[7:0],
                                    st_ff.amode[UBT_AM_CL_BIT],
                                    psel_mode);
            nxt_st.line = 1'b0;
          end
        end
        default: begin
          // Timer count and status are read only
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.tctl <= UBT_TCTL_RESET;
      st_ff.cmp <= UBT_CMP_RESET;
      st_ff.amode <= UBT_AM_RESET;
      st_ff.rdata <= 32'h0000_0000;
      st_ff.rdy <= 1'b0;
      st_ff.err <= 1'b0;
      st_ff.transmit_shift_register <= UBT_TX_IDLE;
      st_ff.smp <= 4'h0;
      st_ff.bitn <= 3'h0;
      st_ff.stop_n <= 1'b0;
      st_ff.shreg <= 8'h00;
      st_ff.par <= 1'b0;
      st_ff.line <= 1'b1;
      st_ff.irq <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = st_ff.rdy;
  assign pslverr = st_ff.err;
  assign txd = st_ff.line;
  assign transmit_complete_irq = st_ff.irq;
endmodule
`default_nettype wire

// ==== bench/ubt_uart_tx_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module ubt_uart_tx_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ubt_pkg::UBT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txd,
  input wire logic transmit_complete_irq
);
  import ubt_pkg::*;
  logic acc, wr_tx, rd_cnt, rd_cmp, idle_ff;
  logic [15:0] len_ff;
  assign acc = psel && penable && pready;
  assign wr_tx = acc && pwrite && paddr == UBT_OFS_TX_SHIFT;
  assign rd_cnt = acc && !pwrite && paddr == UBT_OFS_TMR_COUNT;
  assign rd_cmp = acc && !pwrite && paddr == UBT_OFS_CMP_VALUE;
  // Frame activity seen from the bus and the completion interrupt only, no internal state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_ff <= 1'b1;
    else if (wr_tx) idle_ff <= 1'b0;
    else if (transmit_complete_irq) idle_ff <= 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) len_ff <= 16'h0000;
    else if (wr_tx && idle_ff) len_ff <= 16'h0000;
    else len_ff <= len_ff + 16'h0001;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_irq_pulse;
    transmit_complete_irq |=> !transmit_complete_irq;
  endproperty
  property p_irq_line;
    transmit_complete_irq |-> txd;
  endproperty
  property p_idle_line;
    idle_ff |-> txd;
  endproperty
  property p_no_irq;
    idle_ff |-> !transmit_complete_irq;
  endproperty
  // Window fits either start edge reading
  property p_start;
    wr_tx && idle_ff |-> ##2 !txd [*8] ##1 !txd [*7];
  endproperty
  property p_len;
    transmit_complete_irq |-> len_ff >= 16'h008C;
  endproperty
  property p_cnt_w;
    rd_cnt |-> prdata[31:10] == 22'h000000;
  endproperty
  property p_cmp_w;
    rd_cmp |-> prdata[31:10] == 22'h000000;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq wide");
  a_irq_line: assert property (p_irq_line) else $error("irq line");
  a_idle_line: assert property (p_idle_line) else $error("idle low");
  a_no_irq: assert property (p_no_irq) else $error("stray irq");
  a_start: assert property (p_start) else $error("start bit");
  a_len: assert property (p_len) else $error("short frame");
  a_cnt_w: assert property (p_cnt_w) else $error("count width");
  a_cmp_w: assert property (p_cmp_w) else $error("cmp width");
  c_frame: cover property (transmit_complete_irq);
  c_ign: cover property (wr_tx && !idle_ff);
  c_err: cover property (pslverr);
endmodule
bind ubt_uart_tx ubt_uart_tx_monitor u_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txd(txd),
  .transmit_complete_irq(transmit_complete_irq));
`default_nettype wire

// ==== bench/ubt_line_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ubt_line_model (
  input wire logic pclk,
  input wire logic txd,
  input wire logic [15:0] bit_len,
  input wire logic [3:0] n_bits,
  output logic [11:0] frame
);
  // Remote receiver: resyncs on each start edge, samples mid-cell
  initial begin
    frame = 12'hFFF;
    forever begin
      @(negedge txd);
      frame = 12'hFFF;
      repeat (bit_len / 2) @(posedge pclk);
      for (int i = 0; i < n_bits; i++) begin
        repeat (bit_len) @(posedge pclk);
        frame[i] = txd;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ubt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, txd, irq, er;
  logic [15:0] bl = 16'h0010;
  logic [3:0] nb = 4'h0;
  logic [11:0] frame;
  logic [7:0] modes [4] = '{8'h09, 8'h15, 8'h21, 8'h3D};
  int n_mismatch = 0, compares = 0, cyc = 0, n_irq = 0;
  always #50 pclk = ~pclk;
  ubt_uart_tx DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
    .transmit_complete_irq(irq));
  ubt_line_model u_line (.pclk(pclk), .txd(txd), .bit_len(bl),
    .n_bits(nb), .frame(frame));
  task finish_test;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [11:0] expf(input logic [7:0] d,
    input logic [7:0] m);
    logic [11:0] f;
    logic p;
    int k;
    k = m[UBT_AM_CL_BIT] ? 8 : 7;
    f = 12'hFFF;
    for (int i = 0; i < k; i++) f[i] = d[i];
    p = ^(d & (k == 8 ? 8'hFF : 8'h7F));
    if (m[5:4] == UBT_PAR_ZERO) f[k] = 1'b0;
    if (m[5:4] == UBT_PAR_ODD) f[k] = ~p;
    if (m[5:4] == UBT_PAR_EVEN) f[k] = p;
    return f;
  endfunction
  task send(input logic [7:0] d, input logic [7:0] m);
    int t;
    nb = 4'((m[3] ? 8 : 7) + (m[5:4] != 2'h0) + (m[2] ? 2 : 1));
    apb(1'b1, UBT_OFS_TX_SHIFT, {24'h0, d});
    apb(1'b1, UBT_OFS_TX_SHIFT, 32'h0);
    apb(1'b0, UBT_OFS_TX_STATUS, 32'h0);
    chk(rd, 32'h1);
    t = 0;
    do begin
      @(negedge pclk);
      t++;
    end while (irq !== 1'b1 && t < 4000);
    chk({31'h0, irq}, 32'h1);
    chk({20'h0, frame}, {20'h0, expf(d, m)});
    apb(1'b0, UBT_OFS_TX_STATUS, 32'h0);
    chk(rd, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, UBT_OFS_TMR_CTRL, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h0);
    apb(1'b0, UBT_OFS_ASYNC_MODE, 32'h0);
    chk(rd, 32'h80);
    apb(1'b1, UBT_OFS_TMR_CTRL, 32'h06);
    apb(1'b0, UBT_OFS_TMR_CTRL, 32'h0);
    chk(rd, 32'h06);
    apb(1'b1, UBT_OFS_TMR_COUNT, 32'h3FF);
    apb(1'b0, UBT_OFS_TMR_COUNT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, UBT_OFS_CMP_VALUE, 32'hFFFFFFFF);
    apb(1'b0, UBT_OFS_CMP_VALUE, 32'h0);
    chk(rd, 32'h3FF);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (int j = 0; j < 4; j++) begin
      apb(1'b1, UBT_OFS_ASYNC_MODE, {24'h0, modes[j]});
      send(8'h96 + 8'(j), modes[j]);
    end
    // Generator path: m=1, n=0 gives 64 clocks a bit
    bl = 16'h0040;
    apb(1'b1, UBT_OFS_ASYNC_MODE, 32'h08);
    apb(1'b1, UBT_OFS_CMP_VALUE, 32'h1);
    apb(1'b1, UBT_OFS_TMR_CTRL, 32'h0);
    apb(1'b1, UBT_OFS_TMR_CTRL, 32'h1);
    apb(1'b0, UBT_OFS_TMR_COUNT, 32'h0);
    chk({31'h0, rd <= 32'h1}, 32'h1);
    send(8'h5A, 8'h08);
    apb(1'b1, UBT_OFS_TMR_CTRL, 32'h0);
    apb(1'b0, UBT_OFS_TMR_COUNT, 32'h0);
    chk(rd, 32'h0);
    bl = 16'h0100;
    apb(1'b1, UBT_OFS_TMR_CTRL, 32'h2);
    apb(1'b1, UBT_OFS_TMR_CTRL, 32'h3);
    send(8'hC3, 8'h08);
    // Next byte straight after the completion, then a reset cut into a frame
    bl = 16'h0010;
    apb(1'b1, UBT_OFS_ASYNC_MODE, 32'h09);
    send(8'h3C, 8'h09);
    send(8'hE1, 8'h09);
    apb(1'b1, UBT_OFS_TX_SHIFT, 32'hA5);
    repeat (40) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, txd}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (300) begin
      @(negedge pclk);
      if (irq !== 1'b0) n_irq++;
    end
    chk(n_irq, 32'h0);
    apb(1'b0, UBT_OFS_TX_STATUS, 32'h0);
    chk(rd, 32'h0);
    finish_test;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test;
    end
  end
endmodule
`default_nettype wire
